// ==== bench/etrtx_msg_tx_props.sv ====
// port checker for the frame builder
`timescale 1ns/1ps
module etrtx_msg_tx_props
(
    input wire        clk,
    input wire        rst,
    input wire [7:0]  own_addr,
    input wire        frame_valid,
    input wire        frame_ready,
    input wire [28:0] frame_id,
    input wire [63:0] frame_data
);
    wire [7:0]  ps = frame_id[15:8];
    wire [63:0] d  = frame_data;
    wire        rt = frame_valid && frame_id[23:16] == 8'hf0;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RST: assert property (disable iff (1'b0) rst |=> !frame_valid)
        else $error("valid right after reset");
    AST_HOLD: assert property (frame_valid && !frame_ready |=> frame_valid && $stable({frame_id, d}))
        else $error("frame dropped or changed while stalled");
    AST_ID: assert property (frame_valid |-> frame_id[28:24] == 5'h18 && frame_id[7:0] == own_addr)
        else $error("bad id header");
    AST_KIND: assert property (frame_valid |-> frame_id[23:8] inside {16'hf000, 16'hfeee, 16'hfea4})
        else $error("bad format or specific");
    AST_MODE: assert property (rt |-> d[7:4] == 4'hf && d[3:0] inside {4'ha, 4'he})
        else $error("bad torque mode");
    AST_RNA: assert property (rt |-> d[31:16] == 16'hffff && d[47:40] == 8'hff && d[63:56] == 8'hff)
        else $error("retarder fill not all ones");
    AST_TQ: assert property (rt |-> d[15:8] <= 8'hfa)
        else $error("torque above range");
    AST_ANA: assert property (frame_valid && ps == 8'hee |-> d[47:32] == 16'hffff && d[63:56] == 8'hff)
        else $error("frame a fill not all ones");
    AST_BNA: assert property (frame_valid && ps == 8'ha4 |-> d[15:0] == 16'hffff)
        else $error("frame b fill not all ones");
    cover property (frame_valid && !frame_ready);
    cover property (frame_valid && frame_ready && ps == 8'hee);
    cover property (frame_valid && frame_ready && ps == 8'ha4);
endmodule

bind etrtx_msg_tx etrtx_msg_tx_props etrtx_msg_tx_props_i (.clk(clk), .rst(rst), .own_addr(own_addr),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_id(frame_id), .frame_data(frame_data));

// ==== bench/etrtx_msg_tx_tb.sv ====
// self-checking bench for the frame builder
`timescale 1ns/1ps
`include "etrtx_regs_regs.vh"
module etrtx_msg_tx_tb;
    localparam RP = 20;
    localparam TP = 60;
    reg               clk = 1'b0, rst = 1'b1, ret_mode_braking = 1'b1;
    reg               fast = 1'b1, slow = 1'b0, hold = 1'b0, upd = 1'b1;
    reg        [7:0]  own_addr = 8'h3c, ret_ctrl_addr = 8'h00, ret_select_lvl = 8'hfa;
    reg signed [7:0]  ret_torque_pct = -8'sd125;
    reg signed [8:0]  coolant_degc = -9'sd41, fuel_degc = 9'sd210, intercool_degc = 9'sd211;
    reg signed [16:0] oil_temp_32th = 17'sd55519, egr_dp_128th = -17'sd32000, egr_temp_32th = 17'sd55520;
    reg        [15:0] ecu_temp_cnt = 16'h1234;
    wire              frame_valid, frame_ready;
    wire       [28:0] frame_id;
    wire       [63:0] frame_data;
    integer           seed = 75, r, k, n0, cyc = 0, last_a = 0, n_take = 0, errors = 0, n_checks = 0;

    always #12.5 clk = ~clk;

    etrtx_msg_tx #(.RET_PERIOD(RP), .TEMP_PERIOD(TP)) etrtx_msg_tx_i (.clk(clk), .rst(rst),
        .own_addr(own_addr), .ret_torque_pct(ret_torque_pct), .ret_mode_braking(ret_mode_braking),
        .ret_ctrl_addr(ret_ctrl_addr), .ret_select_lvl(ret_select_lvl), .coolant_degc(coolant_degc),
        .fuel_degc(fuel_degc), .intercool_degc(intercool_degc), .oil_temp_32th(oil_temp_32th),
        .ecu_temp_cnt(ecu_temp_cnt), .egr_dp_128th(egr_dp_128th), .egr_temp_32th(egr_temp_32th),
        .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_id(frame_id), .frame_data(frame_data));
    etrtx_sink etrtx_sink_i (.clk(clk), .slow(slow), .hold(hold), .frame_ready(frame_ready));

    function [7:0] c8(input integer x);
        c8 = x < 0 ? 8'h00 : x > 250 ? 8'hfa : x[7:0];
    endfunction
    function [15:0] c16(input integer x);
        c16 = x < 0 ? 16'h0000 : x > 64255 ? 16'hfaff : x[15:0];
    endfunction
    function [92:0] exp_frame(input [7:0] ps);
        reg [63:0] d;
        begin
            if (ps == 8'hee)
                d = {8'hff, c8(intercool_degc + 40), 16'hffff, c16(oil_temp_32th + 8736),
                     c8(fuel_degc + 40), c8(coolant_degc + 40)};
            else if (ps == 8'ha4)
                d = {c16(egr_temp_32th + 8736), c16(egr_dp_128th + 32000), ecu_temp_cnt, 16'hffff};
            else
                d = {8'hff, ret_select_lvl, 8'hff, ret_ctrl_addr, 16'hffff, c8(ret_torque_pct + 125),
                     4'hf, ret_mode_braking ? `ETRTX_MODE_BRAKE : `ETRTX_MODE_OTHER};
            exp_frame = {3'h6, 2'h0, ps == 8'h00 ? 8'hf0 : 8'hfe, ps, own_addr, d};
        end
    endfunction

    task chk(input string name, input [92:0] e, input [92:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e)
            begin
                errors = errors + 1;
                $display("BAD %0s exp %h got %h", name, e, g);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // new values only after frame b, the last of a burst, so nothing queued is stale
    task rnd;
        begin
            r = $random(seed);
            ret_torque_pct <= r[7:0];
            ret_mode_braking <= r[8];
            coolant_degc <= r[17:9];
            fuel_degc <= r[26:18];
            own_addr <= r[31:24];
            r = $random(seed);
            intercool_degc <= r[8:0];
            oil_temp_32th <= r[25:9];
            ret_ctrl_addr <= r[31:24];
            r = $random(seed);
            ecu_temp_cnt <= r[15:0];
            egr_dp_128th <= r[31:15];
            r = $random(seed);
            egr_temp_32th <= r[16:0];
            ret_select_lvl <= r[31:24];
        end
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (rst)
            last_a = 0;
        else if (frame_valid === 1'b1 && frame_ready === 1'b1)
        begin
            n_take = n_take + 1;
            chk("frame", exp_frame(frame_id[15:8]), {frame_id, frame_data});
            if (frame_id[15:8] == 8'hee)
            begin
                if (fast && last_a > 0)
                    chk("a gap", TP, cyc - last_a);
                last_a = cyc;
            end
            if (upd && frame_id[15:8] == 8'ha4)
                rnd;
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 200 && frame_valid !== 1'b1; k = k + 1)
            @(negedge clk);
        chk("first frame", 1, k >= RP && k <= RP + 6);
        if (k == 200)
            results;
        repeat (400) @(posedge clk);
        fast <= 1'b0;
        slow <= 1'b1;
        repeat (400) @(posedge clk);
        upd <= 1'b0;
        slow <= 1'b0;
        hold <= 1'b1;
        repeat (250) @(posedge clk);
        hold <= 1'b0;
        @(negedge clk);
        n0 = n_take;
        repeat (9) @(negedge clk);
        // four queued, one in the output stage and one merged frame per kind leave back to back;
        // expiries during the drain queue behind them, so exactly eight are taken here
        chk("burst", 8, n_take - n0);
        @(posedge clk);
        upd <= 1'b1;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("valid in reset", 0, frame_valid);
        @(posedge clk);
        rst <= 1'b0;
        fast <= 1'b1;
        repeat (300) @(posedge clk);
        results;
    end
endmodule

// ==== bench/etrtx_sink.sv ====
// far-side consumer: takes frames at once, stalls at random, or holds off
`timescale 1ns/1ps
module etrtx_sink
(
    input wire clk,
    input wire slow,
    input wire hold,
    output reg frame_ready
);
    integer seed = 75;
    always @(posedge clk)
        frame_ready <= !hold && (!slow || $random(seed) % 2 == 0);
endmodule

// ==== core/etrtx_msg_tx.v ====
// periodic retarder and engine temperature frame builder with output fifo
// What this block does
// - retarder byte 2 carries actual torque as percent plus 125, one percent per count.
// - retarder torque mode nibble is 1010 for braking system and 1110 otherwise, nothing else is sent.
// - retarder byte 5 carries the source address of the controlling device unchanged.
// - retarder byte 7 carries the non-engine selection level in 0.4 percent counts.
// - retarder byte 4 holds only undefined or unsupported bit groups.
// - temperature frame a byte 1 carries coolant temperature in degrees plus 40.
// - temperature frame a bytes 3 and 4 carry oil temperature in 1/32 degree counts plus 273 degrees.
// - temperature frame a byte 2 carries fuel and byte 7 intercooler temperature, degrees plus 40.
// - both temperature frames go out once a second, 8 bytes, page 0, format 254, priority 6, specific 238 and 164.
// - temperature frame b bytes 3 and 4 carry the controller electronics temperature count.
// - temperature frame b bytes 5 and 6 carry recirculation differential pressure in 1/128 kPa plus 250 kPa.
// - temperature frame b bytes 7 and 8 carry recirculation temperature in 1/32 degree counts plus 273 degrees.
`timescale 1ns/1ps
`include "etrtx_regs_regs.vh"

module etrtx_fifo
#(
    parameter W     = 93,
    parameter DEPTH = 4,
    parameter AW    = 2
)
(
    input  wire          clk,
    input  wire          rst,
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    output reg           out_valid,
    input  wire          out_ready,
    output reg  [W-1:0]  out_data
);
    // depth must be a power of two so the pointers wrap on their own
    localparam [AW:0] FULL = DEPTH[AW:0];
    localparam [AW:0] NONE = {(AW+1){1'b0}};

    reg  [W-1:0]  mem [0:DEPTH-1];
    reg  [AW-1:0] wp;
    reg  [AW-1:0] rp;
    reg  [AW:0]   cnt;
    wire          push;
    wire          load;

    assign in_ready = (cnt != FULL);
    assign push     = in_valid && in_ready;
    // the output stage refills whenever it is empty or being drained
    assign load     = (cnt != NONE) && (!out_valid || out_ready);

    always @(posedge clk)
    begin
        if (push)
        begin
            mem[wp] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            wp        <= {AW{1'b0}};
            rp        <= {AW{1'b0}};
            cnt       <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {W{1'b0}};
        end
        else
        begin
            if (push)
            begin
                wp <= wp + 1'b1;
            end
            if (load)
            begin
                out_data  <= mem[rp];
                rp        <= rp + 1'b1;
                out_valid <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid <= 1'b0;
            end
            case ({push, load})
                2'b10:   cnt <= cnt + 1'b1;
                2'b01:   cnt <= cnt - 1'b1;
                default: cnt <= cnt;
            endcase
        end
    end
endmodule

// adds the offset to a signed reading and clamps the sum into 0..top
module etrtx_scale
#(
    parameter IW = 10,
    parameter OW = 8
)
(
    input  wire signed [IW-1:0] raw,
    input  wire signed [IW-1:0] ofs,
    input  wire signed [IW-1:0] top,
    output wire        [OW-1:0] q
);
    wire signed [IW-1:0] sum;
    wire                 below;
    wire                 above;

    // callers sign-extend by at least one bit so the sum cannot wrap; a wild reading clamps
    // instead of landing in the range that reads as not available
    assign sum   = raw + ofs;
    assign below = sum[IW-1];
    assign above = (sum > top);
    assign q     = below ? {OW{1'b0}} : (above ? top[OW-1:0] : sum[OW-1:0]);
endmodule

module etrtx_msg_tx
#(
    parameter RET_PERIOD  = `ETRTX_RATE_RET_MS * `ETRTX_CLK_KHZ,
    parameter TEMP_PERIOD = `ETRTX_RATE_TEMP_MS * `ETRTX_CLK_KHZ,
    parameter CW          = 26,
    parameter FIFO_DEPTH  = 4,
    parameter FIFO_AW     = 2
)
(
    input  wire               clk,
    input  wire               rst,
    input  wire [7:0]         own_addr,
    input  wire signed [7:0]  ret_torque_pct,
    input  wire               ret_mode_braking,
    input  wire [7:0]         ret_ctrl_addr,
    input  wire [7:0]         ret_select_lvl,
    input  wire signed [8:0]  coolant_degc,
    input  wire signed [8:0]  fuel_degc,
    input  wire signed [8:0]  intercool_degc,
    input  wire signed [16:0] oil_temp_32th,
    input  wire [15:0]        ecu_temp_cnt,
    input  wire signed [16:0] egr_dp_128th,
    input  wire signed [16:0] egr_temp_32th,
    output wire               frame_valid,
    input  wire               frame_ready,
    output wire [28:0]        frame_id,
    output wire [63:0]        frame_data
);
    localparam integer  RET_END   = RET_PERIOD - 1;
    localparam integer  TEMP_END  = TEMP_PERIOD - 1;
    localparam [CW-1:0] RET_LAST  = RET_END[CW-1:0];
    localparam [CW-1:0] TEMP_LAST = TEMP_END[CW-1:0];
    localparam          FW        = 93;
    localparam          DW        = 64;

    reg  [CW-1:0] ret_cnt;
    reg  [CW-1:0] temp_cnt;
    reg           pend_ret;
    reg           pend_a;
    reg           pend_b;
    wire          exp_ret;
    wire          exp_temp;
    wire          sel_ret;
    wire          sel_a;
    wire          sel_b;
    wire          push_valid;
    wire          push_ready;
    wire          push;
    wire [7:0]    ret_b1;
    wire [7:0]    ret_b2;
    wire [7:0]    ret_b4;
    wire [7:0]    tmp_cool;
    wire [7:0]    tmp_fuel;
    wire [7:0]    tmp_icool;
    wire [15:0]   tmp_oil;
    wire [15:0]   tmp_dp;
    wire [15:0]   tmp_egr;
    wire [63:0]   data_ret;
    wire [63:0]   data_a;
    wire [63:0]   data_b;
    reg  [7:0]    next_ps;
    reg  [7:0]    next_pf;
    reg  [63:0]   next_data;
    wire [FW-1:0] push_word;
    wire [FW-1:0] pop_word;

    assign exp_ret  = (ret_cnt == RET_LAST);
    assign exp_temp = (temp_cnt == TEMP_LAST);

    always @(posedge clk)
    begin
        if (rst)
        begin
            ret_cnt  <= {CW{1'b0}};
            temp_cnt <= {CW{1'b0}};
        end
        else
        begin
            ret_cnt  <= exp_ret ? {CW{1'b0}} : ret_cnt + 1'b1;
            temp_cnt <= exp_temp ? {CW{1'b0}} : temp_cnt + 1'b1;
        end
    end

    // retarder first; while the fifo is full a frame waits, and a later period of the same kind merges into it
    assign sel_ret    = pend_ret;
    assign sel_a      = pend_a && !pend_ret;
    assign sel_b      = pend_b && !pend_ret && !pend_a;
    assign push_valid = pend_ret || pend_a || pend_b;
    assign push       = push_valid && push_ready;

    // a new period that lands on the push cycle keeps the flag set
    always @(posedge clk)
    begin
        if (rst)
        begin
            pend_ret <= 1'b0;
            pend_a   <= 1'b0;
            pend_b   <= 1'b0;
        end
        else
        begin
            pend_ret <= (pend_ret && !(push && sel_ret)) || exp_ret;
            pend_a   <= (pend_a && !(push && sel_a)) || exp_temp;
            pend_b   <= (pend_b && !(push && sel_b)) || exp_temp;
        end
    end

    // retarder payload
    assign ret_b1   = {`ETRTX_NA_NIB, ret_mode_braking ? `ETRTX_MODE_BRAKE : `ETRTX_MODE_OTHER};
    etrtx_scale #(.IW(10), .OW(8)) u_torque
    (
        .raw ({ret_torque_pct[7], ret_torque_pct[7], ret_torque_pct}),
        .ofs (`ETRTX_TORQUE_OFS),
        .top (`ETRTX_MAX8),
        .q   (ret_b2)
    );
    assign ret_b4   = `ETRTX_NA_BYTE;
    assign data_ret = {`ETRTX_NA_BYTE, ret_select_lvl, `ETRTX_NA_BYTE, ret_ctrl_addr,
                       ret_b4, `ETRTX_NA_BYTE, ret_b2, ret_b1};

    // first temperature payload
    etrtx_scale #(.IW(10), .OW(8)) u_cool
    (
        .raw ({coolant_degc[8], coolant_degc}),
        .ofs (`ETRTX_TEMP8_OFS),
        .top (`ETRTX_MAX8),
        .q   (tmp_cool)
    );
    etrtx_scale #(.IW(10), .OW(8)) u_fuel
    (
        .raw ({fuel_degc[8], fuel_degc}),
        .ofs (`ETRTX_TEMP8_OFS),
        .top (`ETRTX_MAX8),
        .q   (tmp_fuel)
    );
    etrtx_scale #(.IW(10), .OW(8)) u_icool
    (
        .raw ({intercool_degc[8], intercool_degc}),
        .ofs (`ETRTX_TEMP8_OFS),
        .top (`ETRTX_MAX8),
        .q   (tmp_icool)
    );
    etrtx_scale #(.IW(18), .OW(16)) u_oil
    (
        .raw ({oil_temp_32th[16], oil_temp_32th}),
        .ofs (`ETRTX_TEMP16_OFS),
        .top (`ETRTX_MAX16),
        .q   (tmp_oil)
    );
    assign data_a    = {`ETRTX_NA_BYTE, tmp_icool, `ETRTX_NA_WORD,
                        tmp_oil[15:8], tmp_oil[7:0], tmp_fuel, tmp_cool};

    // second temperature payload; the electronics temperature arrives already in counts
    etrtx_scale #(.IW(18), .OW(16)) u_dp
    (
        .raw ({egr_dp_128th[16], egr_dp_128th}),
        .ofs (`ETRTX_PRES_OFS),
        .top (`ETRTX_MAX16),
        .q   (tmp_dp)
    );
    etrtx_scale #(.IW(18), .OW(16)) u_egr
    (
        .raw ({egr_temp_32th[16], egr_temp_32th}),
        .ofs (`ETRTX_TEMP16_OFS),
        .top (`ETRTX_MAX16),
        .q   (tmp_egr)
    );
    assign data_b   = {tmp_egr[15:8], tmp_egr[7:0], tmp_dp[15:8], tmp_dp[7:0],
                       ecu_temp_cnt[15:8], ecu_temp_cnt[7:0], `ETRTX_NA_WORD};

    always @*
    begin
        next_pf   = `ETRTX_PF_TEMP;
        next_ps   = `ETRTX_PS_TEMP_B;
        next_data = data_b;
        if (sel_ret)
        begin
            next_pf   = `ETRTX_PF_RET;
            next_ps   = `ETRTX_PS_RET;
            next_data = data_ret;
        end
        else if (sel_a)
        begin
            next_ps   = `ETRTX_PS_TEMP_A;
            next_data = data_a;
        end
    end

    assign push_word = {`ETRTX_PRIO, `ETRTX_RSVD, `ETRTX_DPAGE, next_pf, next_ps, own_addr, next_data};

    etrtx_fifo
    #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    )
    u_fifo
    (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (frame_valid),
        .out_ready (frame_ready),
        .out_data  (pop_word)
    );

    assign frame_id   = pop_word[FW-1:DW];
    assign frame_data = pop_word[DW-1:0];
endmodule

// ==== core/etrtx_regs_regs.vh ====
// constants for the engine temperature and retarder frame builder
`ifndef ETRTX_REGS_REGS_VH
`define ETRTX_REGS_REGS_VH

// clock rate in kHz and message periods in ms
`define ETRTX_CLK_KHZ       40000
`define ETRTX_RATE_RET_MS   100
`define ETRTX_RATE_TEMP_MS  1000

// identifier fields
`define ETRTX_PRIO          3'h6
`define ETRTX_RSVD          1'h0
`define ETRTX_DPAGE         1'h0
`define ETRTX_PF_RET        8'hf0
`define ETRTX_PS_RET        8'h00
`define ETRTX_PF_TEMP       8'hfe
`define ETRTX_PS_TEMP_A     8'hee
`define ETRTX_PS_TEMP_B     8'ha4

// torque mode codes and fill values
`define ETRTX_MODE_BRAKE    4'ha
`define ETRTX_MODE_OTHER    4'he
`define ETRTX_NA_NIB        4'hf
`define ETRTX_NA_BYTE       8'hff
`define ETRTX_NA_WORD       16'hffff

// scaling offsets in counts
`define ETRTX_TORQUE_OFS    10'sh07d
`define ETRTX_TEMP8_OFS     10'sh028
`define ETRTX_TEMP16_OFS    18'sh02220
`define ETRTX_PRES_OFS      18'sh07d00

// clamp limits, bottom and top of the valid data range
`define ETRTX_ZERO8         10'sh000
`define ETRTX_MAX8          10'sh0fa
`define ETRTX_MAX8_VAL      8'hfa
`define ETRTX_ZERO16        18'sh00000
`define ETRTX_MAX16         18'sh0faff
`define ETRTX_MAX16_VAL     16'hfaff

`endif
